// ### design/irq_pkg.sv
// Package with register map, field layout, vectors and bus constants of the interrupt block.
package irq_pkg;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam int         ADDR_W       = 8;
   localparam logic [7:0] IDX_CONTROL  = 8'h0b;
   localparam logic [7:0] IDX_STATUS   = 8'h0c;
   localparam logic [7:0] IDX_MASK     = 8'h0d;
   localparam logic [ADDR_W-1:0] ADDR_CONTROL = ADDR_W'({IDX_CONTROL, 2'b00});
   localparam logic [ADDR_W-1:0] ADDR_STATUS  = ADDR_W'({IDX_STATUS, 2'b00});
   localparam logic [ADDR_W-1:0] ADDR_MASK    = ADDR_W'({IDX_MASK, 2'b00});

   // ----------------------------------------------------------------------
   // Control register fields and reset values
   // ----------------------------------------------------------------------
   localparam int        NSRC        = 3;
   localparam int        BIT_GIE     = 0;
   localparam int        EN_LO       = 1;
   localparam int        FLAG_LO     = 4;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [NSRC-1:0] SRC_NONE  = 3'h0;
   localparam logic [NSRC-1:0] SRC_PIN   = 3'h1;
   localparam logic [NSRC-1:0] SRC_TIMER = 3'h2;
   localparam logic [NSRC-1:0] SRC_CONV  = 3'h4;

   // ----------------------------------------------------------------------
   // Event status bits
   // ----------------------------------------------------------------------
   localparam int EV_W    = 3;
   localparam int EV_ACK  = 0;
   localparam int EV_HELD = 1;
   localparam int EV_WAKE = 2;

   // ----------------------------------------------------------------------
   // Core side
   // ----------------------------------------------------------------------
   localparam int              PC_W        = 12;
   localparam int              STACK_DEPTH = 6;
   localparam logic [PC_W-1:0] VEC_NONE    = 12'h000;
   localparam logic [PC_W-1:0] VEC_PIN     = 12'h004;
   localparam logic [PC_W-1:0] VEC_TIMER   = 12'h008;
   localparam logic [PC_W-1:0] VEC_CONV    = 12'h00c;

   // ----------------------------------------------------------------------
   // AXI4-Lite
   // ----------------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_RESP = 2'b10} wr_state_t;
   typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_DATA = 2'b10} rd_state_t;

endpackage

// ### design/stack_if.sv
// Interface between the interrupt controller and its return-address stack.
interface stack_if;
   import irq_pkg::*;
   logic            push;
   logic            pop;
   logic [PC_W-1:0] push_pc;
   logic [PC_W-1:0] top_pc;
   logic            full;
   modport ctrl (output push, output pop, output push_pc, input top_pc, input full);
   modport mem  (input push, input pop, input push_pc, output top_pc, output full);
endinterface

// ### design/return_stack.sv
// Return-address stack with registered read data and a full flag.
module return_stack
   import irq_pkg::*;
#(
   parameter int DEPTH = STACK_DEPTH
) (
   input wire logic clk_sys,
   input wire logic nrst,
   stack_if.mem     stk
);
   localparam int PTR_W = $clog2(DEPTH);
   localparam int CNT_W = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][PC_W-1:0] mem;
      logic [PTR_W-1:0]           ptr;
      logic [CNT_W-1:0]           count;
      logic [PC_W-1:0]            top;
   } stack_state_t;

   stack_state_t s;
   stack_state_t next_s;

   function automatic logic [PTR_W-1:0] step(input logic [PTR_W-1:0] p, input logic up);
      if (up) return (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
      return (p == '0) ? PTR_W'(DEPTH - 1) : p - 1'b1;
   endfunction

   // A push onto a full stack overwrites the oldest entry, as a plain call does.
   always_comb begin
      next_s = s;
      if (stk.push) begin
         next_s.mem[s.ptr] = stk.push_pc;
         next_s.ptr        = step(s.ptr, 1'b1);
         if (s.count != CNT_W'(DEPTH)) next_s.count = s.count + 1'b1;
      end else if (stk.pop) begin
         next_s.ptr = step(s.ptr, 1'b0);
         next_s.top = s.mem[step(s.ptr, 1'b0)];
         if (s.count != '0) next_s.count = s.count - 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign stk.top_pc = s.top;
   assign stk.full   = (s.count == CNT_W'(DEPTH));

   property p_depth;
      @(posedge clk_sys) disable iff (!nrst) s.count <= CNT_W'(DEPTH);
   endproperty
   a_depth: assert property (p_depth) else $error("stack count beyond depth");

endmodule // return_stack

// ### design/three_source_irq_controller.sv
// Three-source interrupt controller with AXI4-Lite registers and a return stack.
module three_source_irq_controller
   import irq_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              nrst,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   output logic                   irq_out,
   input  wire logic              pin_irq_n,
   input  wire logic              timer_overflow,
   input  wire logic              conv_done,
   input  wire logic              phase_two_clock,
   input  wire logic [PC_W-1:0]   pc_in,
   input  wire logic              call_push,
   input  wire logic              return_from_call,
   input  wire logic              return_from_irq,
   input  wire logic              halt_enter,
   output logic                   irq_ack,
   output logic [PC_W-1:0]        irq_vector,
   output logic [PC_W-1:0]        ret_pc,
   output logic                   stack_full,
   output logic                   halted,
   output logic                   wake
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      wr_state_t         wst;
      rd_state_t         rst;
      logic              aw_held;
      logic [ADDR_W-1:0] aw_addr;
      logic              w_held;
      logic [31:0]       w_data;
      logic              w_lane0;
      logic [1:0]        bresp;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
      logic              gie;
      logic [NSRC-1:0]   en;
      logic [NSRC-1:0]   flag;
      logic [EV_W-1:0]   ev;
      logic [EV_W-1:0]   mask;
      logic              sync1;
      logic              sync2;
      logic              pin_prev;
      logic              halted;
      logic [NSRC-1:0]   wake_block;
      logic              wake;
      logic              ack;
      logic [PC_W-1:0]   vector;
   } ctrl_state_t;

   ctrl_state_t s;
   ctrl_state_t next_s;

   stack_if stk ();

   return_stack #(
      .DEPTH (STACK_DEPTH)
   ) u_stack (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .stk     (stk.mem)
   );

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   function automatic logic [NSRC-1:0] pick(input logic [NSRC-1:0] pend);
      if (pend[0]) return SRC_PIN;
      if (pend[1]) return SRC_TIMER;
      if (pend[2]) return SRC_CONV;
      return SRC_NONE;
   endfunction

   function automatic logic [PC_W-1:0] vec_of(input logic [NSRC-1:0] sel);
      if (sel == SRC_PIN) return VEC_PIN;
      if (sel == SRC_TIMER) return VEC_TIMER;
      if (sel == SRC_CONV) return VEC_CONV;
      return VEC_NONE;
   endfunction

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      return (a == ADDR_CONTROL) || (a == ADDR_STATUS) || (a == ADDR_MASK);
   endfunction

   // ----------------------------------------------------------------------
   // Request decision
   // ----------------------------------------------------------------------
   logic [NSRC-1:0] pend;
   logic [NSRC-1:0] sel;
   logic [NSRC-1:0] hw_set;
   logic            pin_fall;
   logic            take;
   logic            held;
   logic            wr_go;
   logic            wake_now;

   assign pin_fall = s.pin_prev && !s.sync2;
   assign hw_set   = {conv_done, timer_overflow, pin_fall};
   assign pend     = s.en & s.flag;
   assign sel      = pick(pend);
   // Sampling only on the phase-two pulse makes a request that lands between
   // two pulses wait for the later one.
   assign take     = phase_two_clock && s.gie && (|pend) && !stk.full;
   assign held     = phase_two_clock && s.gie && (|pend) && stk.full;
   assign wr_go    = (s.wst == WR_IDLE) && s.aw_held && s.w_held;
   assign wake_now = s.halted && |(hw_set & ~s.wake_block);

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      next_s      = s;
      next_s.ack  = 1'b0;
      next_s.wake = 1'b0;

      // Only the second stage looks at the first.
      next_s.sync1    = pin_irq_n;
      next_s.sync2    = s.sync1;
      next_s.pin_prev = s.sync2;

      if (awvalid && awready) begin
         next_s.aw_held = 1'b1;
         next_s.aw_addr = awaddr;
      end
      if (wvalid && wready) begin
         next_s.w_held  = 1'b1;
         next_s.w_data  = wdata;
         next_s.w_lane0 = wstrb[0];
      end

      case (s.wst)
         WR_IDLE: begin
            if (wr_go) begin
               next_s.wst     = WR_RESP;
               next_s.aw_held = 1'b0;
               next_s.w_held  = 1'b0;
               next_s.bresp   = mapped(s.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            end
         end
         WR_RESP: begin
            if (bready) next_s.wst = WR_IDLE;
         end
         default: next_s.wst = WR_IDLE;
      endcase

      if (wr_go && s.w_lane0) begin
         if (s.aw_addr == ADDR_CONTROL) begin
            next_s.gie  = s.w_data[BIT_GIE];
            next_s.en   = s.w_data[EN_LO +: NSRC];
            next_s.flag = s.w_data[FLAG_LO +: NSRC];
         end else if (s.aw_addr == ADDR_STATUS) begin
            next_s.ev = s.ev & ~s.w_data[EV_W-1:0];
         end else if (s.aw_addr == ADDR_MASK) begin
            next_s.mask = s.w_data[EV_W-1:0];
         end
      end

      case (s.rst)
         RD_IDLE: begin
            if (arvalid) begin
               next_s.rst   = RD_DATA;
               next_s.rresp = RESP_OKAY;
               if (araddr == ADDR_CONTROL) begin
                  next_s.rdata = 32'(s.flag) << FLAG_LO | 32'(s.en) << EN_LO
                                 | 32'(s.gie);
               end else if (araddr == ADDR_STATUS) begin
                  next_s.rdata = 32'(s.ev);
               end else if (araddr == ADDR_MASK) begin
                  next_s.rdata = 32'(s.mask);
               end else begin
                  next_s.rdata = 32'h0000_0000;
                  next_s.rresp = RESP_SLVERR;
               end
            end
         end
         RD_DATA: begin
            if (rready) next_s.rst = RD_IDLE;
         end
         default: next_s.rst = RD_IDLE;
      endcase

      if (return_from_irq) next_s.gie = 1'b1;

      if (take) begin
         next_s.gie    = 1'b0;
         next_s.flag   = next_s.flag & ~sel;
         next_s.ack    = 1'b1;
         next_s.vector = vec_of(sel);
      end

      // Hardware sets come last so that they beat any clear in the same cycle.
      next_s.flag = next_s.flag | hw_set;

      if (halt_enter && !s.halted) begin
         next_s.halted     = 1'b1;
         next_s.wake_block = s.flag;
      end else if (wake_now) begin
         next_s.halted = 1'b0;
         next_s.wake   = 1'b1;
      end

      next_s.ev = next_s.ev | ({EV_W{1'b0}}
                  | (EV_W'(take) << EV_ACK)
                  | (EV_W'(held) << EV_HELD)
                  | (EV_W'(wake_now) << EV_WAKE));
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         s            <= '0;
         s.wst        <= WR_IDLE;
         s.rst        <= RD_IDLE;
         s.gie        <= CONTROL_RESET[BIT_GIE];
         s.en         <= CONTROL_RESET[EN_LO +: NSRC];
         s.flag       <= CONTROL_RESET[FLAG_LO +: NSRC];
         s.sync1      <= 1'b1;
         s.sync2      <= 1'b1;
         s.pin_prev   <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs and stack hookup
   // ----------------------------------------------------------------------
   // Only the program counter goes onto the stack; the core saves the rest.
   assign stk.push    = take || call_push;
   assign stk.push_pc = pc_in;
   assign stk.pop     = (return_from_call || return_from_irq) && !take;

   assign awready    = !s.aw_held && (s.wst == WR_IDLE);
   assign wready     = !s.w_held && (s.wst == WR_IDLE);
   assign bvalid     = (s.wst == WR_RESP);
   assign bresp      = s.bresp;
   assign arready    = (s.rst == RD_IDLE);
   assign rvalid     = (s.rst == RD_DATA);
   assign rdata      = s.rdata;
   assign rresp      = s.rresp;
   assign irq_out    = |(s.ev & s.mask);
   assign irq_ack    = s.ack;
   assign irq_vector = s.vector;
   assign ret_pc     = stk.top_pc;
   assign stack_full = stk.full;
   assign halted     = s.halted;
   assign wake       = s.wake;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   property p_pin_vec;
      @(posedge clk_sys) disable iff (!nrst)
         take && pend[0] |=> irq_ack && irq_vector == VEC_PIN && !s.gie
                             && (!s.flag[0] || $past(pin_fall));
   endproperty
   a_pin_vec: assert property (p_pin_vec) else $error("pin vector wrong");

   property p_timer_vec;
      @(posedge clk_sys) disable iff (!nrst)
         take && !pend[0] && pend[1] |=> irq_ack && irq_vector == VEC_TIMER && !s.gie;
   endproperty
   a_timer_vec: assert property (p_timer_vec) else $error("timer vector wrong");

   property p_conv_vec;
      @(posedge clk_sys) disable iff (!nrst)
         take && pend == SRC_CONV |=> irq_ack && irq_vector == VEC_CONV && !s.gie;
   endproperty
   a_conv_vec: assert property (p_conv_vec) else $error("converter vector wrong");

   property p_ack_gate;
      @(posedge clk_sys) disable iff (!nrst)
         !phase_two_clock || !s.gie || stk.full |=> !irq_ack;
   endproperty
   a_ack_gate: assert property (p_ack_gate) else $error("acknowledge not gated");

   property p_pin_edge;
      @(posedge clk_sys) disable iff (!nrst)
         s.pin_prev && !s.sync2 |=> s.flag[0];
   endproperty
   a_pin_edge: assert property (p_pin_edge) else $error("pin edge not flagged");

   property p_flag_hold;
      @(posedge clk_sys) disable iff (!nrst)
         s.flag[1] && !take && !wr_go |=> s.flag[1];
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");

   property p_return_from_irq;
      @(posedge clk_sys) disable iff (!nrst)
         return_from_irq && !take && !wr_go |=> s.gie;
   endproperty
   a_return_from_irq: assert property (p_return_from_irq) else $error("irq return left gie clear");

   property p_ret_keep;
      @(posedge clk_sys) disable iff (!nrst)
         return_from_call && !return_from_irq && !take && !wr_go |=> s.gie == $past(s.gie);
   endproperty
   a_ret_keep: assert property (p_ret_keep) else $error("call return changed gie");

   property p_push;
      @(posedge clk_sys) disable iff (!nrst)
         take |-> stk.push && stk.push_pc == pc_in && !stk.pop;
   endproperty
   a_push: assert property (p_push) else $error("acknowledge without push");

   property p_wake;
      @(posedge clk_sys) disable iff (!nrst)
         s.halted && |(hw_set & ~s.wake_block) |=> wake && !s.halted;
   endproperty
   a_wake: assert property (p_wake) else $error("wake missed");

   property p_bit7;
      @(posedge clk_sys) disable iff (!nrst)
         rvalid |-> rdata[31:7] == 25'h000_0000;
   endproperty
   a_bit7: assert property (p_bit7) else $error("upper bits not zero");

endmodule // three_source_irq_controller

// ### bench/core_model.sv
// Core sequencer model that issues the phase-two sampling pulse.
module core_model (
   input  wire logic clk_sys,
   input  wire logic nrst,
   output logic      phase_two_clock
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] phase;

   // One pulse every four system cycles, as an instruction cycle would give.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         phase           <= 2'h0;
         phase_two_clock <= 1'b0;
      end else begin
         phase           <= phase + 2'h1;
         phase_two_clock <= (phase == 2'h3);
      end
   end
endmodule // core_model

// ### bench/three_source_irq_controller_tb.sv
// Register-level bench of the three-source interrupt controller.
module three_source_irq_controller_tb;
   import irq_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 0, nrst = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, rd;
   logic [3:0] wstrb = 4'hf;
   logic [1:0] bresp, rresp, rr;
   logic awready, wready, bvalid, arready, rvalid, irq_out, irq_ack, stack_full, halted, wake;
   logic pin_irq_n = 1, timer_overflow = 0, conv_done = 0, phase_two_clock;
   logic call_push = 0, return_from_call = 0, return_from_irq = 0, halt_enter = 0;
   logic [PC_W-1:0] pc_in = 0, irq_vector, ret_pc;
   logic [PC_W-1:0] acks[$];
   int errors = 0, n_checks = 0;
   int wakes = 0;

   always #2.5 clk_sys = ~clk_sys;

   core_model i_core_model (.clk_sys(clk_sys), .nrst(nrst), .phase_two_clock(phase_two_clock));

   three_source_irq_controller i_three_source_irq_controller (
      .clk_sys(clk_sys), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .irq_out(irq_out), .pin_irq_n(pin_irq_n), .timer_overflow(timer_overflow),
      .conv_done(conv_done), .phase_two_clock(phase_two_clock), .pc_in(pc_in),
      .call_push(call_push), .return_from_call(return_from_call),
      .return_from_irq(return_from_irq), .halt_enter(halt_enter), .irq_ack(irq_ack),
      .irq_vector(irq_vector), .ret_pc(ret_pc), .stack_full(stack_full), .halted(halted),
      .wake(wake));

   // Acknowledges are one cycle long, so they are gathered at the falling edge, half a cycle after launch.
   always @(negedge clk_sys) begin
      if (irq_ack === 1'b1) acks.push_back(irq_vector);
      if (wake === 1'b1) wakes++;
   end

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // Handshakes are judged at the falling edge, where inputs and ready are settled.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ha, hw, hb, done;
      int t;
      done = 0;
      t = 0;
      awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
      while (!done && t < 100) begin
         @(negedge clk_sys);
         ha = awvalid && awready;
         hw = wvalid && wready;
         hb = bvalid;
         if (hb) chk("bresp", bresp, er);
         @(posedge clk_sys);
         if (ha) awvalid <= 0;
         if (hw) wvalid <= 0;
         if (hb) bready <= 0;
         done = hb;
         t++;
      end
      // One idle edge keeps the next call from raising bready in this time step.
      @(posedge clk_sys);
      if (!done) chk("write timeout", 0, 1);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic ha, hr, done;
      int t;
      done = 0;
      t = 0;
      araddr <= a; arvalid <= 1; rready <= 1;
      while (!done && t < 100) begin
         @(negedge clk_sys);
         ha = arvalid && arready;
         hr = rvalid;
         rd = rdata;
         rr = rresp;
         @(posedge clk_sys);
         if (ha) arvalid <= 0;
         if (hr) rready <= 0;
         done = hr;
         t++;
      end
      @(posedge clk_sys);
      if (!done) chk("read timeout", 0, 1);
      chk("rdata", rd, e);
      chk("rresp", rr, er);
   endtask

   task automatic want_ack(input logic [PC_W-1:0] v);
      int t;
      t = 0;
      while (acks.size() == 0 && t < 40) begin
         tick(1);
         t++;
      end
      if (acks.size() > 0) chk("vector", acks.pop_front(), v);
      else chk("ack", 0, 1);
   endtask

   task automatic no_ack();
      tick(16);
      chk("ack count", 32'(acks.size()), 0);
   endtask

   task automatic pin_fall();
      pin_irq_n <= 0;
      tick(6);
      pin_irq_n <= 1;
      tick(4);
   endtask

   `define PULSE(s) begin s <= 1; tick(1); s <= 0; tick(1); end

   task automatic stop_test();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      #100us;
      errors++;
      stop_test();
   end

   initial begin
      tick(4);
      nrst <= 1;
      tick(2);
      rdc(ADDR_CONTROL, 0, RESP_OKAY);
      rdc(8'h00, 0, RESP_SLVERR);
      wr(ADDR_CONTROL, 32'h81, RESP_OKAY);
      rdc(ADDR_CONTROL, 32'h01, RESP_OKAY);
      wr(ADDR_CONTROL, 32'hfe, RESP_OKAY);
      rdc(ADDR_CONTROL, 32'h7e, RESP_OKAY);
      no_ack();
      wr(ADDR_CONTROL, 32'h0e, RESP_OKAY);
      rdc(ADDR_CONTROL, 32'h0e, RESP_OKAY);
      pin_fall();
      rdc(ADDR_CONTROL, 32'h1e, RESP_OKAY);
      `PULSE(timer_overflow)
      `PULSE(conv_done)
      no_ack();
      rdc(ADDR_CONTROL, 32'h7e, RESP_OKAY);
      pc_in <= 12'h123;
      wr(ADDR_CONTROL, 32'h7f, RESP_OKAY);
      want_ack(VEC_PIN);
      rdc(ADDR_CONTROL, 32'h6e, RESP_OKAY);
      pc_in <= 12'h456;
      return_from_irq <= 1;
      tick(1);
      return_from_irq <= 0;
      @(negedge clk_sys);
      chk("ret_pc", ret_pc, 12'h123);
      want_ack(VEC_TIMER);
      rdc(ADDR_CONTROL, 32'h4e, RESP_OKAY);
      `PULSE(return_from_irq)
      want_ack(VEC_CONV);
      rdc(ADDR_CONTROL, 32'h0e, RESP_OKAY);
      `PULSE(return_from_call)
      rdc(ADDR_CONTROL, 32'h0e, RESP_OKAY);
      for (int i = 0; i < STACK_DEPTH; i++) begin
         chk("stack_full", stack_full, 0);
         `PULSE(call_push)
      end
      chk("stack_full", stack_full, 1);
      `PULSE(timer_overflow)
      wr(ADDR_CONTROL, 32'h25, RESP_OKAY);
      no_ack();
      rdc(ADDR_CONTROL, 32'h25, RESP_OKAY);
      rdc(ADDR_STATUS, 32'h3, RESP_OKAY);
      `PULSE(return_from_call)
      want_ack(VEC_TIMER);
      `PULSE(return_from_call)
      wr(ADDR_CONTROL, 32'h05, RESP_OKAY);
      `PULSE(timer_overflow)
      want_ack(VEC_TIMER);
      wr(ADDR_MASK, 32'h1, RESP_OKAY);
      chk("irq_out", irq_out, 1);
      wr(ADDR_STATUS, 32'h7, RESP_OKAY);
      chk("irq_out", irq_out, 0);
      rdc(ADDR_STATUS, 0, RESP_OKAY);
      wr(ADDR_MASK, 32'h4, RESP_OKAY);
      wr(ADDR_CONTROL, 32'h00, RESP_OKAY);
      `PULSE(halt_enter)
      chk("halted", halted, 1);
      `PULSE(conv_done)
      tick(2);
      chk("halted", halted, 0);
      chk("irq_out", irq_out, 1);
      `PULSE(halt_enter)
      `PULSE(conv_done)
      tick(2);
      chk("halted", halted, 1);
      pin_fall();
      chk("halted", halted, 0);
      chk("wake count", wakes, 2);
      stop_test();
   end
endmodule // three_source_irq_controller_tb
